// file: sim/img_source.sv
// behavioural source of configuration image words
`timescale 1ns/100ps
`default_nettype none
module img_source (
   // clock
   input wire logic ref_clk,
   // image word stream
   output logic img_valid,
   output logic [7:0] img_addr,
   output logic [15:0] img_data,
   output logic img_last
);
   // ==========
   // word strobe
   initial begin
      img_valid = 1'b0;
      img_addr = 8'h00;
      img_data = 16'h0000;
      img_last = 1'b0;
   end
   task automatic send(input logic [7:0] a, input logic [15:0] d,
                       input logic lst);
      @(posedge ref_clk);
      img_valid <= 1'b1;
      img_addr <= a;
      img_data <= d;
      img_last <= lst;
      @(posedge ref_clk);
      // idle lines flip so stale data is never mistaken for a word
      img_valid <= 1'b0;
      img_last <= 1'b0;
      img_addr <= ~a;
      img_data <= ~d;
   endtask
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// self-checking bench for the configuration word loader
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   // ==========
   // signals
   logic ref_clk, rst, hsel, hwrite, hreadyout, hresp, loaded;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic img_valid, img_last;
   logic [7:0] img_addr;
   logic [15:0] img_data;
   logic [2:0] port_soft_rst;
   int miscompares = 0;
   int num_checks = 0;
   int cycles = 0;
   logic [2:0] aux_t [3] = '{3'h5, 3'h2, 3'h7};
   logic [1:0] pme_t [3] = '{2'h1, 2'h2, 2'h3};
   logic [7:0] db_t [3] = '{8'h3c, 8'hc3, 8'h5a};
   logic nsr_t [3] = '{1'b1, 1'b0, 1'b1};
   // ==========
   // instances
   img_source src (.ref_clk(ref_clk), .img_valid(img_valid),
      .img_addr(img_addr), .img_data(img_data), .img_last(img_last));
   pm_config_word_loader uut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .img_valid(img_valid),
      .img_addr(img_addr), .img_data(img_data), .img_last(img_last),
      .loaded(loaded), .port_soft_rst(port_soft_rst));
   // ==========
   // clock and timeout
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         miscompares++;
         end_of_test();
      end
   end
   // ==========
   // shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      if (miscompares == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic ahb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {20'h0, a};
      // hready is read at the rising edge, before the design updates
      do begin
         @(posedge ref_clk);
      end while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do begin
         @(posedge ref_clk);
      end while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   function automatic logic [11:0] cap_a(input int p);
      return pm_cfg_pkg::PMCAP_OFF + pm_cfg_pkg::PORT_STRIDE * p[11:0];
   endfunction
   function automatic logic [11:0] dat_a(input int p);
      return pm_cfg_pkg::PMDATA_OFF + pm_cfg_pkg::PORT_STRIDE * p[11:0];
   endfunction
   function automatic logic [31:0] exp_cap(input int p);
      return {2'b00, pme_t[p], 1'b0, 2'b11, aux_t[p], 22'h0};
   endfunction
   function automatic logic [31:0] exp_dat(input int p, input logic [1:0] s);
      return {db_t[p], 20'h0, nsr_t[p], 1'b0, s};
   endfunction
   // ==========
   // scenarios
   task automatic t_reset();
      @(negedge ref_clk);
      check(hreadyout, 1'b1);
      check(hrdata, 32'h0);
      check({hresp, loaded, port_soft_rst}, 5'h0);
   endtask
   task automatic t_load_stall();
      logic [31:0] rd;
      fork
         ahb(1'b0, pm_cfg_pkg::STATUS_OFF, 32'h0, rd);
         begin
            repeat (4) @(negedge ref_clk);
            check(hreadyout, 1'b0); // held off before load
            src.send(8'h4f, {15'h0, nsr_t[0]}, 1'b0);
            for (int p = 0; p < 3; p++) begin
               src.send(8'h50 + 8'(2 * p),
                  {8'ha5, pme_t[p], 2'b11, aux_t[p], 1'b1}, 1'b0);
               src.send(8'h51 + 8'(2 * p),
                  {db_t[p], 7'h2a, (p < 2) ? nsr_t[p + 1] : 1'b0}, p == 2);
            end
         end
      join
      check(rd, 32'h1); // loaded before answer
      check(loaded, 1'b1);
   endtask
   task automatic t_fields();
      logic [31:0] rd;
      for (int p = 0; p < 3; p++) begin
         ahb(1'b0, cap_a(p), 32'h0, rd);
         check(rd, exp_cap(p)); // capability fields
         ahb(1'b0, dat_a(p), 32'h0, rd);
         check(rd, exp_dat(p, 2'h0)); // data and flag
      end
   endtask
   task automatic t_readonly();
      logic [31:0] rd;
      ahb(1'b1, cap_a(0), 32'hffff_fffc, rd);
      ahb(1'b1, dat_a(2), 32'hffff_fff0, rd);
      ahb(1'b0, cap_a(0), 32'h0, rd);
      check(rd, exp_cap(0)); // capability not writable
      ahb(1'b0, dat_a(2), 32'h0, rd);
      check(rd, exp_dat(2, 2'h0)); // data byte not writable
      ahb(1'b0, 12'h800, 32'h0, rd);
      check(rd, 32'h0);
   endtask
   task automatic t_late_word();
      logic [31:0] rd;
      src.send(8'h50, 16'h0000, 1'b1);
      src.send(8'h53, 16'h0000, 1'b0);
      ahb(1'b0, cap_a(0), 32'h0, rd);
      check(rd, exp_cap(0)); // image frozen after last
      ahb(1'b0, dat_a(2), 32'h0, rd);
      check(rd, exp_dat(2, 2'h0)); // flag frozen after last
   endtask
   task automatic t_soft_reset(input int p);
      logic [31:0] rd;
      logic [2:0] seen;
      seen = 3'h0;
      ahb(1'b1, dat_a(p), 32'h3, rd);
      ahb(1'b0, dat_a(p), 32'h0, rd);
      check(rd, exp_dat(p, 2'h3));
      ahb(1'b1, dat_a(p), 32'h0, rd);
      repeat (3) begin
         #1 seen = seen | port_soft_rst;
         @(posedge ref_clk);
      end
      check(seen, nsr_t[p] ? 3'h0 : 3'(1 << p)); // suppression
   endtask
   // ==========
   // main sequence
   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      htrans = 2'h0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      repeat (3) @(posedge ref_clk);
      t_reset();
      @(posedge ref_clk);
      rst <= 1'b0;
      t_load_stall();
      t_fields();
      t_readonly();
      t_late_word();
      t_soft_reset(1);
      t_soft_reset(0);
      end_of_test();
   end
endmodule
`default_nettype wire

// file: src/pm_cfg_pkg.sv
// shared constants for the power-management configuration loader
package pm_cfg_pkg;
   // ===========================================
   // ports and image word addresses
   localparam int NPORTS = 3;
   localparam logic [7:0] CAP_WORD0 = 8'h50;
   localparam logic [7:0] DATA_WORD0 = 8'h51;
   localparam logic [7:0] NSR_WORD0 = 8'h4f;
   localparam logic [7:0] WORD_STRIDE = 8'h02;
   // ===========================================
   // image word bit positions
   localparam int IMG_NSR_BIT = 0;
   localparam int IMG_AUX_LSB = 1;
   localparam int IMG_D1_BIT = 4;
   localparam int IMG_D2_BIT = 5;
   localparam int IMG_PME_LSB = 6;
   localparam int IMG_DATA_LSB = 8;
   // ===========================================
   // configuration register bit positions
   localparam int CFG_PS_LSB = 0;
   localparam int CFG_NSR_BIT = 3;
   localparam int CFG_AUX_LSB = 22;
   localparam int CFG_D1_BIT = 25;
   localparam int CFG_D2_BIT = 26;
   localparam int CFG_PME_LSB = 28;
   localparam int CFG_DATA_LSB = 24;
   localparam int STAT_LOADED_BIT = 0;
   // ===========================================
   // byte offsets on the register bus
   localparam logic [11:0] STATUS_OFF = 12'h000;
   localparam logic [11:0] PMCAP_OFF = 12'h040;
   localparam logic [11:0] PMDATA_OFF = 12'h044;
   localparam logic [11:0] PORT_STRIDE = 12'h100;
   // ===========================================
   // reset values and power states
   localparam logic [2:0] AUX_RST = 3'h0;
   localparam logic [1:0] PME_RST = 2'h0;
   localparam logic D_SUPPORT_RST = 1'b0;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic NSR_RST = 1'b0;
   localparam logic [1:0] PS_D0 = 2'h0;
   localparam logic [1:0] PS_D3 = 2'h3;
endpackage

// file: src/pm_config_word_loader.sv
// configuration image loader with an AHB-Lite view of the port pm registers
`timescale 1ns/100ps
`default_nettype none
module pm_config_word_loader (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // configuration image source
   input wire logic img_valid,
   input wire logic [7:0] img_addr,
   input wire logic [15:0] img_data,
   input wire logic img_last,
   // status and per-port soft reset
   output logic loaded,
   output logic [2:0] port_soft_rst
);
   localparam int NP = pm_cfg_pkg::NPORTS;

   typedef struct packed {
      logic ap_valid;
      logic ap_write;
      logic [11:0] ap_addr;
      logic ready;
      logic loaded;
      logic [31:0] rdata;
      logic [NP-1:0] soft_rst;
   } top_s;

   top_s st;
   top_s next_st;

   logic accept;
   logic complete;
   logic img_take;
   logic [31:0] rd_word;
   logic [NP-1:0] ps_we;
   logic [NP-1:0][2:0] aux;
   logic [NP-1:0] d1;
   logic [NP-1:0] d2;
   logic [NP-1:0][1:0] pme;
   logic [NP-1:0][7:0] pm_data;
   logic [NP-1:0] nsr;
   logic [NP-1:0][1:0] pstate;

   function automatic logic [11:0] cap_off(input int p);
      cap_off = 12'(pm_cfg_pkg::PMCAP_OFF + 12'(p) * pm_cfg_pkg::PORT_STRIDE);
   endfunction

   function automatic logic [11:0] data_off(input int p);
      data_off = 12'(pm_cfg_pkg::PMDATA_OFF
                     + 12'(p) * pm_cfg_pkg::PORT_STRIDE);
   endfunction

   // ===========================================
   // image intake
   // words after the last one are ignored
   assign img_take = img_valid && !st.loaded;

   // ===========================================
   // per-port fields
   for (genvar g = 0; g < NP; g++) begin : port
      localparam logic [7:0] CW =
         8'(pm_cfg_pkg::CAP_WORD0 + 8'(g) * pm_cfg_pkg::WORD_STRIDE);
      localparam logic [7:0] DW =
         8'(pm_cfg_pkg::DATA_WORD0 + 8'(g) * pm_cfg_pkg::WORD_STRIDE);
      localparam logic [7:0] NW =
         8'(pm_cfg_pkg::NSR_WORD0 + 8'(g) * pm_cfg_pkg::WORD_STRIDE);
      pm_port_regs #(
         .CAP_WORD(CW),
         .DATA_WORD(DW),
         .NSR_WORD(NW)
      ) regs (
         .ref_clk(ref_clk),
         .rst(rst),
         .img_take(img_take),
         .img_addr(img_addr),
         .img_data(img_data),
         .ps_we(ps_we[g]),
         .ps_wdata(hwdata[pm_cfg_pkg::CFG_PS_LSB +: 2]),
         .aux(aux[g]),
         .d1(d1[g]),
         .d2(d2[g]),
         .pme(pme[g]),
         .pm_data(pm_data[g]),
         .nsr(nsr[g]),
         .pstate(pstate[g])
      );
   end

   // ===========================================
   // bus handshake
   // once the image is loaded every transfer takes one wait state; a read is formed from
   // registered fields so hrdata comes straight from a flop
   assign accept = hsel && htrans[1] && hready;
   assign complete = st.ap_valid && st.ready;
   // stall until the image is in
   assign hreadyout = !st.ap_valid || st.ready;
   assign hrdata = st.rdata;
   assign hresp = 1'b0;
   assign loaded = st.loaded;
   assign port_soft_rst = st.soft_rst;

   always_comb begin
      for (int p = 0; p < NP; p++) begin
         ps_we[p] = complete && st.ap_write && st.ap_addr == data_off(p);
      end
   end

   // ===========================================
   // read mux
   // unmapped offsets read as zero and writes there are dropped
   always_comb begin
      rd_word = 32'h0000_0000;
      if (st.ap_addr == pm_cfg_pkg::STATUS_OFF) begin
         rd_word[pm_cfg_pkg::STAT_LOADED_BIT] = st.loaded;
      end
      for (int p = 0; p < NP; p++) begin
         if (st.ap_addr == cap_off(p)) begin
            rd_word[pm_cfg_pkg::CFG_AUX_LSB +: 3] = aux[p];
            rd_word[pm_cfg_pkg::CFG_D1_BIT] = d1[p];
            rd_word[pm_cfg_pkg::CFG_D2_BIT] = d2[p];
            rd_word[pm_cfg_pkg::CFG_PME_LSB +: 2] = pme[p];
         end
         if (st.ap_addr == data_off(p)) begin
            rd_word[pm_cfg_pkg::CFG_DATA_LSB +: 8] = pm_data[p];
            rd_word[pm_cfg_pkg::CFG_NSR_BIT] = nsr[p];
            rd_word[pm_cfg_pkg::CFG_PS_LSB +: 2] = pstate[p];
         end
      end
   end

   // ===========================================
   // next state
   always_comb begin
      next_st = st;
      next_st.soft_rst = '0;
      if (img_take && img_last) begin
         next_st.loaded = 1'b1;
      end
      if (st.ap_valid && !st.ready && st.loaded) begin
         next_st.ready = 1'b1;
         next_st.rdata = rd_word;
      end
      if (complete) begin
         next_st.ap_valid = 1'b0;
         next_st.ready = 1'b0;
      end
      if (accept) begin
         next_st.ap_valid = 1'b1;
         next_st.ready = 1'b0;
         next_st.ap_write = hwrite;
         next_st.ap_addr = haddr[11:0];
      end
      // leaving d3 for d0 resets the port unless suppressed
      for (int p = 0; p < NP; p++) begin
         next_st.soft_rst[p] = ps_we[p]
            && pstate[p] == pm_cfg_pkg::PS_D3
            && hwdata[pm_cfg_pkg::CFG_PS_LSB +: 2] == pm_cfg_pkg::PS_D0
            && !nsr[p];
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ===========================================
   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   logic rd0_cap;
   logic rd1_cap;
   logic rd2_cap;
   logic rd0_dat;
   logic rd1_dat;
   logic rd2_dat;
   logic wr0_dat;
   assign rd0_cap = st.ap_valid && !st.ready && st.loaded
                    && st.ap_addr == cap_off(0);
   assign rd1_cap = st.ap_valid && !st.ready && st.loaded
                    && st.ap_addr == cap_off(1);
   assign rd2_cap = st.ap_valid && !st.ready && st.loaded
                    && st.ap_addr == cap_off(2);
   assign rd0_dat = st.ap_valid && !st.ready && st.loaded
                    && st.ap_addr == data_off(0);
   assign rd1_dat = st.ap_valid && !st.ready && st.loaded
                    && st.ap_addr == data_off(1);
   assign rd2_dat = st.ap_valid && !st.ready && st.loaded
                    && st.ap_addr == data_off(2);
   assign wr0_dat = complete && st.ap_write && st.ap_addr == data_off(0);

   aux_copy_a: assert property (
      img_take && img_addr == 8'h50
      |=> aux[0] == $past(img_data[3:1]))
      else $error("port 0 aux current not taken from word 50h");

   port1_cap_a: assert property (
      img_take && img_addr == 8'h52
      |=> {pme[1], d2[1], d1[1], aux[1]} == $past(img_data[7:1]))
      else $error("port 1 capability not taken from word 52h");

   port2_cap_a: assert property (
      img_take && img_addr == 8'h54
      |=> {pme[2], d2[2], d1[2], aux[2]} == $past(img_data[7:1]))
      else $error("port 2 capability not taken from word 54h");

   d1_readback_a: assert property (
      rd0_cap |=> hreadyout && hrdata[25] == d1[0]
                  && hrdata[24:22] == aux[0])
      else $error("port 0 d1 or aux misplaced in read data");

   d2_readback_a: assert property (
      rd1_cap |=> hrdata[26] == d2[1] && hrdata[21:0] == 22'h0)
      else $error("port 1 d2 bit misplaced in read data");

   pme_readback_a: assert property (
      rd2_cap |=> hrdata[29:28] == pme[2] && hrdata[31:30] == 2'h0)
      else $error("port 2 pme bits misplaced in read data");

   data0_load_a: assert property (
      img_take && img_addr == 8'h51
      |=> pm_data[0] == $past(img_data[15:8]))
      else $error("port 0 data byte not taken from word 51h");

   data1_load_a: assert property (
      img_take && img_addr == 8'h53
      |=> pm_data[1] == $past(img_data[15:8]))
      else $error("port 1 data byte not taken from word 53h");

   data2_load_a: assert property (
      img_take && img_addr == 8'h55
      |=> pm_data[2] == $past(img_data[15:8]) ##1 $stable(pm_data[2])
          or img_take)
      else $error("port 2 data byte not taken from word 55h");

   nsr1_load_a: assert property (
      img_take && img_addr == 8'h51 |=> nsr[1] == $past(img_data[0]))
      else $error("port 1 suppression not taken from word 51h");

   nsr2_load_a: assert property (
      img_take && img_addr == 8'h53 |=> nsr[2] == $past(img_data[0]))
      else $error("port 2 suppression not taken from word 53h");

   stall_unloaded_a: assert property (
      st.ap_valid && !st.loaded |-> !hreadyout)
      else $error("bus answered before the image was loaded");

   answer_bound_a: assert property (
      st.ap_valid && st.loaded && !st.ready |=> hreadyout)
      else $error("loaded slave did not answer in one wait state");

   frozen_after_a: assert property (
      st.loaded |=> $stable(aux) && $stable(pm_data) && $stable(nsr))
      else $error("image fields changed after loading finished");

   soft_rst_pulse_a: assert property (
      port_soft_rst[1] |-> !nsr[1] ##1 !port_soft_rst[1])
      else $error("soft reset pulse wrong for port 1");

   d1_copy_a: assert property (
      img_take && img_addr == pm_cfg_pkg::CAP_WORD0
      |=> d1[0] == $past(img_data[pm_cfg_pkg::IMG_D1_BIT]))
      else $error("port 0 d1 support not taken from image bit 4");

   d2_copy_a: assert property (
      img_take && img_addr == pm_cfg_pkg::CAP_WORD0
      |=> d2[0] == $past(img_data[pm_cfg_pkg::IMG_D2_BIT]))
      else $error("port 0 d2 support not taken from image bit 5");

   pme_copy_a: assert property (
      img_take && img_addr == pm_cfg_pkg::CAP_WORD0
      |=> pme[0] == $past(img_data[7:6]))
      else $error("port 0 pme support not taken from image bits 7:6");

   nsr0_load_a: assert property (
      img_take && img_addr == pm_cfg_pkg::NSR_WORD0
      |=> nsr[0] == $past(img_data[0]))
      else $error("port 0 suppression not taken from word 4fh");

   data0_readback_a: assert property (
      rd0_dat |=> hrdata[31:24] == pm_data[0] && hrdata[3] == nsr[0])
      else $error("port 0 data byte or flag misplaced in read data");

   data1_readback_a: assert property (
      rd1_dat |=> hrdata[31:24] == pm_data[1] && hrdata[3] == nsr[1])
      else $error("port 1 data byte or flag misplaced in read data");

   data2_readback_a: assert property (
      rd2_dat |=> hrdata[31:24] == pm_data[2] && hrdata[3] == nsr[2])
      else $error("port 2 data byte or flag misplaced in read data");

   loaded_on_last_a: assert property (
      img_take && img_last |=> loaded)
      else $error("last image word did not mark the image loaded");

   loaded_sticky_a: assert property (
      loaded |=> loaded)
      else $error("loaded flag fell without a reset");

   one_wait_a: assert property (
      accept |=> !hreadyout)
      else $error("accepted transfer answered without a wait state");

   rdata_hold_a: assert property (
      !(st.ap_valid && !st.ready && st.loaded) |=> $stable(hrdata))
      else $error("read data changed outside a read answer");

   pstate_write_a: assert property (
      wr0_dat |=> pstate[0] == $past(hwdata[1:0]))
      else $error("port 0 power state write did not land");

   soft_rst_gate_a: assert property (
      (port_soft_rst & nsr) == 3'h0)
      else $error("soft reset pulsed on a port that suppresses it");

   read_done_c: cover property (
      accept && !hwrite ##1 !hreadyout ##1 hreadyout);
   write_done_c: cover property (complete && st.ap_write);
   stalled_c: cover property (st.ap_valid && !st.loaded ##1 st.loaded);
   soft_rst_c: cover property (|port_soft_rst);
   data_read_c: cover property (rd2_dat ##1 complete);
endmodule
`default_nettype wire

// file: src/pm_port_regs.sv
// per-port power-management fields captured from the configuration image
`timescale 1ns/100ps
`default_nettype none
module pm_port_regs #(
   parameter logic [7:0] CAP_WORD = 8'h00,
   parameter logic [7:0] DATA_WORD = 8'h00,
   parameter logic [7:0] NSR_WORD = 8'h00
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // image words, already gated by the loader
   input wire logic img_take,
   input wire logic [7:0] img_addr,
   input wire logic [15:0] img_data,
   // software power-state write
   input wire logic ps_we,
   input wire logic [1:0] ps_wdata,
   // captured fields
   output logic [2:0] aux,
   output logic d1,
   output logic d2,
   output logic [1:0] pme,
   output logic [7:0] pm_data,
   output logic nsr,
   output logic [1:0] pstate
);
   typedef struct packed {
      logic [2:0] aux;
      logic d1;
      logic d2;
      logic [1:0] pme;
      logic [7:0] data;
      logic nsr;
      logic [1:0] pstate;
   } port_s;

   port_s st;
   port_s next_st;

   // ===========================================
   // capture
   always_comb begin
      next_st = st;
      if (img_take && img_addr == CAP_WORD) begin
         next_st.aux = img_data[pm_cfg_pkg::IMG_AUX_LSB +: 3];
         next_st.d1 = img_data[pm_cfg_pkg::IMG_D1_BIT];
         next_st.d2 = img_data[pm_cfg_pkg::IMG_D2_BIT];
         next_st.pme = img_data[pm_cfg_pkg::IMG_PME_LSB +: 2];
      end
      if (img_take && img_addr == DATA_WORD) begin
         next_st.data = img_data[pm_cfg_pkg::IMG_DATA_LSB +: 8];
      end
      if (img_take && img_addr == NSR_WORD) begin
         next_st.nsr = img_data[pm_cfg_pkg::IMG_NSR_BIT];
      end
      if (ps_we) begin
         next_st.pstate = ps_wdata;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '{aux: pm_cfg_pkg::AUX_RST,
                 d1: pm_cfg_pkg::D_SUPPORT_RST,
                 d2: pm_cfg_pkg::D_SUPPORT_RST,
                 pme: pm_cfg_pkg::PME_RST,
                 data: pm_cfg_pkg::DATA_RST,
                 nsr: pm_cfg_pkg::NSR_RST,
                 pstate: pm_cfg_pkg::PS_D0};
      end else begin
         st <= next_st;
      end
   end

   assign aux = st.aux;
   assign d1 = st.d1;
   assign d2 = st.d2;
   assign pme = st.pme;
   assign pm_data = st.data;
   assign nsr = st.nsr;
   assign pstate = st.pstate;
endmodule
`default_nettype wire
